// ### design/wdog_irq_status.sv
// Purpose: Watchdog interrupt control, counter and status behind AXI4-Lite
// Assumes: 25 MHz clk, synchronous active-high reset, one bus master
// Notes: Host reset request is a one-cycle pulse on expiry
//
// The register offsets and the AXI4-Lite interface to the registers were decided locally.
`timescale 1ns/10ps
`default_nettype none
module wdog_irq_status
	import wdog_pkg::*;
#(
	parameter int CNT_W = 32
) (
	input wire logic clk,
	input wire logic reset,
	input wire logic debuggerPin,
	input wire logic [7:0] s_axi_awaddr,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic [7:0] s_axi_araddr,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	output logic [31:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready,
	output logic hostIrq,
	output logic hostResetReq,
	output logic eventIrq
);
	if (CNT_W < 2 || CNT_W > 32) begin : g_cntw_check
		$error("CNT_W must be 2..32");
	end
	////////////////////////////////////////////////////////////////////////
	// Register state
	logic [1:0] act_q, act_d;
	logic relaxed_q, relaxed_d;
	logic fwdEn_q, fwdEn_d;
	logic [CNT_W-1:0] period_q, period_d;
	logic [CNT_W-1:0] count_q, count_d;
	logic [EV_COUNT-1:0] mask_q, mask_d;
	logic hostIrq_q, hostIrq_d;
	logic hostRst_q, hostRst_d;
	logic evIrq_q, evIrq_d;
	logic pending;
	logic debugLevel;
	logic active;
	logic expiry;
	logic [EV_COUNT-1:0] evFlags;
	logic [EV_COUNT-1:0] evSet;
	logic [EV_COUNT-1:0] evClr;
	logic ackCmd;
	logic rejectEv;
	// AXI write/read channel state
	logic awOpen_q, awOpen_d, wOpen_q, wOpen_d, bValid_q, bValid_d;
	logic [7:0] awAddr_q, awAddr_d;
	logic [31:0] wData_q, wData_d;
	logic [3:0] wStrb_q, wStrb_d;
	logic [1:0] bResp_q, bResp_d;
	logic arReady_q, arReady_d, rValid_q, rValid_d;
	logic [31:0] rData_q, rData_d;
	logic [1:0] rResp_q, rResp_d;
	logic doWrite;
	logic wrFull;
	////////////////////////////////////////////////////////////////////////
	// Debugger presence pin, filtered
	wdog_sync3 u_dbgSync (
		.clk(clk),
		.reset(reset),
		.pinIn(debuggerPin),
		.level(debugLevel)
	);
	// Activity from selection
	// An attached debugger halts the host, so the dog must not bite
	assign active = (act_q != ACT_NONE) && !debugLevel;
	assign expiry = active && (count_q == '0);
	////////////////////////////////////////////////////////////////////////
	// Write channel: accept address and data in either order
	assign doWrite = !awOpen_q && !wOpen_q && !bValid_q;
	assign wrFull = wStrb_q == 4'hF;
	always_comb begin
		awOpen_d = awOpen_q;
		wOpen_d = wOpen_q;
		awAddr_d = awAddr_q;
		wData_d = wData_q;
		wStrb_d = wStrb_q;
		bValid_d = bValid_q;
		bResp_d = bResp_q;
		if (s_axi_awvalid && awOpen_q) begin
			awOpen_d = 1'b0;
			awAddr_d = s_axi_awaddr;
		end
		if (s_axi_wvalid && wOpen_q) begin
			wOpen_d = 1'b0;
			wData_d = s_axi_wdata;
			wStrb_d = s_axi_wstrb;
		end
		if (doWrite) begin
			awOpen_d = 1'b1;
			wOpen_d = 1'b1;
			bValid_d = 1'b1;
			bResp_d = (awAddr_q > OFF_COUNT || awAddr_q[1:0] != 2'h0) ? RESP_SLVERR : RESP_OKAY;
		end
		if (bValid_q && s_axi_bready) begin
			bValid_d = 1'b0;
		end
	end
	////////////////////////////////////////////////////////////////////////
	// Register writes and commands; partial strobes ignored for CTRL and PERIOD, byte 0 strobe enough for the others
	logic wCtrl, wCmd, wPeriod, wStat, wMask;
	assign wCtrl = doWrite && wrFull && awAddr_q == OFF_CTRL;
	assign wCmd = doWrite && awAddr_q == OFF_CMD && wStrb_q[0];
	assign wPeriod = doWrite && wrFull && awAddr_q == OFF_PERIOD;
	assign wStat = doWrite && awAddr_q == OFF_IRQ_STAT && wStrb_q[0];
	assign wMask = doWrite && awAddr_q == OFF_IRQ_MASK && wStrb_q[0];
	assign ackCmd = wCmd && wData_q[CMD_ACK_BIT];
	// Selection changes refused in safety mode
	assign rejectEv = wCtrl && !relaxed_q && (wData_q[CTRL_ACT_LSB +: 2] != act_q);
	always_comb begin
		act_d = act_q;
		relaxed_d = relaxed_q;
		fwdEn_d = fwdEn_q;
		period_d = period_q;
		mask_d = mask_q;
		if (wCtrl) begin
			relaxed_d = wData_q[CTRL_RELAXED_BIT];
			if (relaxed_q && wData_q[CTRL_ACT_LSB +: 2] != 2'h3) begin
				act_d = wData_q[CTRL_ACT_LSB +: 2];
			end
		end
		if (wPeriod && relaxed_q) begin
			period_d = wData_q[CNT_W-1:0];
		end
		if (wCmd && wData_q[CMD_FWD_EN_BIT]) begin
			fwdEn_d = 1'b1;
		end
		if (wCmd && wData_q[CMD_FWD_DIS_BIT]) begin
			fwdEn_d = 1'b0;
		end
		if (wMask) begin
			mask_d = wData_q[EV_COUNT-1:0];
		end
	end
	////////////////////////////////////////////////////////////////////////
	// Counter: acknowledge deliberately absent
	always_comb begin
		count_d = count_q;
		if (wCmd && wData_q[CMD_RELOAD_BIT]) begin
			count_d = period_q;
		end else if (expiry) begin
			count_d = period_q;
		end else if (active) begin
			count_d = count_q - 1'b1;
		end
	end
	////////////////////////////////////////////////////////////////////////
	// Event flags: pending lives in bit zero
	assign evSet[EV_EXPIRY_BIT] = expiry && act_q == ACT_HOST_IRQ;
	assign evSet[EV_REJECT_BIT] = rejectEv;
	assign evClr[EV_EXPIRY_BIT] = ackCmd || (wStat && wData_q[EV_EXPIRY_BIT]);
	assign evClr[EV_REJECT_BIT] = wStat && wData_q[EV_REJECT_BIT];
	genvar gi;
	generate
		for (gi = 0; gi < EV_COUNT; gi++) begin : g_ev
			wdog_sticky_bit u_bit (
				.clk(clk),
				.reset(reset),
				.setPulse(evSet[gi]),
				.clearPulse(evClr[gi]),
				.flag(evFlags[gi])
			);
		end
	endgenerate
	assign pending = evFlags[EV_EXPIRY_BIT];
	////////////////////////////////////////////////////////////////////////
	// Outputs
	always_comb begin
		hostIrq_d = pending && fwdEn_q;
		hostRst_d = expiry && act_q == ACT_HOST_RESET;
		evIrq_d = |(evFlags & mask_q);
	end
	////////////////////////////////////////////////////////////////////////
	// Read channel
	always_comb begin
		arReady_d = 1'b0;
		rValid_d = rValid_q;
		rData_d = rData_q;
		rResp_d = rResp_q;
		if (rValid_q && s_axi_rready) begin
			rValid_d = 1'b0;
		end
		if (s_axi_arvalid && !arReady_q && !rValid_q) begin
			arReady_d = 1'b1;
			rValid_d = 1'b1;
			rResp_d = RESP_OKAY;
			rData_d = 32'h0000_0000;
			unique case (s_axi_araddr)
				OFF_CTRL: begin
					rData_d[CTRL_ACT_LSB +: 2] = act_q;
					rData_d[CTRL_RELAXED_BIT] = relaxed_q;
					rData_d[CTRL_FWD_BIT] = fwdEn_q;
				end
				OFF_CMD: rData_d = 32'h0000_0000;
				OFF_PERIOD: rData_d[CNT_W-1:0] = period_q;
				OFF_STATUS: begin
					rData_d[ST_PEND_BIT] = pending;
					rData_d[ST_RELAXED_BIT] = relaxed_q;
					rData_d[ST_ACTIVE_BIT] = active;
					rData_d[ST_DEBUG_BIT] = debugLevel;
				end
				OFF_IRQ_STAT: rData_d[EV_COUNT-1:0] = evFlags;
				OFF_IRQ_MASK: rData_d[EV_COUNT-1:0] = mask_q;
				OFF_COUNT: rData_d[CNT_W-1:0] = count_q;
				default: rResp_d = RESP_SLVERR;
			endcase
		end
	end
	////////////////////////////////////////////////////////////////////////
	// Registers
	always_ff @(posedge clk) begin
		if (reset) begin
			act_q <= ACT_RESET;
			relaxed_q <= 1'b0;
			fwdEn_q <= 1'b0;
			period_q <= PERIOD_RESET[CNT_W-1:0];
			count_q <= PERIOD_RESET[CNT_W-1:0];
			mask_q <= '0;
			hostIrq_q <= 1'b0;
			hostRst_q <= 1'b0;
			evIrq_q <= 1'b0;
			awOpen_q <= 1'b1;
			wOpen_q <= 1'b1;
			awAddr_q <= 8'h00;
			wData_q <= 32'h0000_0000;
			wStrb_q <= 4'h0;
			bValid_q <= 1'b0;
			bResp_q <= RESP_OKAY;
			arReady_q <= 1'b0;
			rValid_q <= 1'b0;
			rData_q <= 32'h0000_0000;
			rResp_q <= RESP_OKAY;
		end else begin
			act_q <= act_d;
			relaxed_q <= relaxed_d;
			fwdEn_q <= fwdEn_d;
			period_q <= period_d;
			count_q <= count_d;
			mask_q <= mask_d;
			hostIrq_q <= hostIrq_d;
			hostRst_q <= hostRst_d;
			evIrq_q <= evIrq_d;
			awOpen_q <= awOpen_d;
			wOpen_q <= wOpen_d;
			awAddr_q <= awAddr_d;
			wData_q <= wData_d;
			wStrb_q <= wStrb_d;
			bValid_q <= bValid_d;
			bResp_q <= bResp_d;
			arReady_q <= arReady_d;
			rValid_q <= rValid_d;
			rData_q <= rData_d;
			rResp_q <= rResp_d;
		end
	end
	assign s_axi_awready = awOpen_q;
	assign s_axi_wready = wOpen_q;
	assign s_axi_bvalid = bValid_q;
	assign s_axi_bresp = bResp_q;
	assign s_axi_arready = arReady_q;
	assign s_axi_rvalid = rValid_q;
	assign s_axi_rdata = rData_q;
	assign s_axi_rresp = rResp_q;
	assign hostIrq = hostIrq_q;
	assign hostResetReq = hostRst_q;
	assign eventIrq = evIrq_q;
	////////////////////////////////////////////////////////////////////////
	// Assertions
	a_irq_gate: assert property (@(posedge clk) disable iff (reset) ##1 hostIrq == $past(pending && fwdEn_q))
		else $error("interrupt output not pending and enabled");
	a_fwd_off_hold: assert property (@(posedge clk) disable iff (reset) !fwdEn_q && !wCmd |=> !fwdEn_q)
		else $error("forwarding re-enabled without command");
	a_pend_no_fwd: assert property (@(posedge clk) disable iff (reset) evSet[EV_EXPIRY_BIT] && !fwdEn_q |=> pending)
		else $error("pending lost while forwarding off");
	a_ack_clears: assert property (@(posedge clk) disable iff (reset) ackCmd && !evSet[EV_EXPIRY_BIT] |=> !pending)
		else $error("acknowledge did not clear pending");
	a_ack_keeps_cnt: assert property (@(posedge clk) disable iff (reset)
		ackCmd && !wData_q[CMD_RELOAD_BIT] && active && !expiry |=> count_q == $past(count_q) - 1'b1)
		else $error("acknowledge disturbed the counter");
	a_auto_restart: assert property (@(posedge clk) disable iff (reset) expiry |=> count_q == $past(period_q))
		else $error("counter did not restart after expiry");
	a_reload_period: assert property (@(posedge clk) disable iff (reset)
		wCmd && wData_q[CMD_RELOAD_BIT] |=> count_q == $past(period_q))
		else $error("reload did not use period");
	a_safety_lock: assert property (@(posedge clk) disable iff (reset) !relaxed_q |=> act_q == $past(act_q))
		else $error("selection changed in safety mode");
	a_active_dbg: assert property (@(posedge clk) disable iff (reset) debugLevel |-> !active)
		else $error("watchdog active with debugger attached");
	c_expiry_irq: cover property (@(posedge clk) disable iff (reset) evSet[EV_EXPIRY_BIT] ##[1:40] ackCmd);
	c_host_reset: cover property (@(posedge clk) disable iff (reset) hostRst_q);
	c_rejected: cover property (@(posedge clk) disable iff (reset) rejectEv);
endmodule
`default_nettype wire

// ### design/wdog_pkg.sv
// Purpose: Shared constants for the watchdog interrupt and status block
// Assumes: 32-bit AXI4-Lite register bus, 25 MHz clock
// Notes: Offsets are byte addresses
package wdog_pkg;
	// Register byte offsets
	localparam logic [7:0] OFF_CTRL = 8'h00;
	localparam logic [7:0] OFF_CMD = 8'h04;
	localparam logic [7:0] OFF_PERIOD = 8'h08;
	localparam logic [7:0] OFF_STATUS = 8'h0C;
	localparam logic [7:0] OFF_IRQ_STAT = 8'h10;
	localparam logic [7:0] OFF_IRQ_MASK = 8'h14;
	localparam logic [7:0] OFF_COUNT = 8'h18;
	// Control fields
	localparam int CTRL_ACT_LSB = 0;
	localparam int CTRL_RELAXED_BIT = 2;
	localparam int CTRL_FWD_BIT = 3;
	// Command fields (write one to issue)
	localparam int CMD_RELOAD_BIT = 0;
	localparam int CMD_ACK_BIT = 1;
	localparam int CMD_FWD_EN_BIT = 2;
	localparam int CMD_FWD_DIS_BIT = 3;
	// Status fields
	localparam int ST_PEND_BIT = 0;
	localparam int ST_RELAXED_BIT = 1;
	localparam int ST_ACTIVE_BIT = 2;
	localparam int ST_DEBUG_BIT = 3;
	// Event status bits
	localparam int EV_EXPIRY_BIT = 0;
	localparam int EV_REJECT_BIT = 1;
	localparam int EV_COUNT = 2;
	// Reset values
	localparam logic [31:0] PERIOD_RESET = 32'h0000_FFFF;
	localparam logic [1:0] ACT_RESET = 2'h0;
	// AXI responses
	localparam logic [1:0] RESP_OKAY = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;
	// Expiry action choices
	typedef enum logic [1:0] {
		ACT_NONE = 2'h0,
		ACT_HOST_RESET = 2'h1,
		ACT_HOST_IRQ = 2'h2
	} expiry_action_t;
endpackage

// ### design/wdog_sticky_bit.sv
// Purpose: One sticky event bit, set by hardware, cleared by software
// Assumes: Single clock, synchronous active-high reset
// Notes: Set wins over clear in the same cycle
`timescale 1ns/10ps
`default_nettype none
module wdog_sticky_bit (
	input wire logic clk,
	input wire logic reset,
	input wire logic setPulse,
	input wire logic clearPulse,
	output logic flag
);
	logic flag_q;
	logic flag_d;
	// Set beats clear so no event is lost
	always_comb begin
		flag_d = flag_q;
		if (clearPulse) begin
			flag_d = 1'b0;
		end
		if (setPulse) begin
			flag_d = 1'b1;
		end
	end
	always_ff @(posedge clk) begin
		if (reset) begin
			flag_q <= 1'b0;
		end else begin
			flag_q <= flag_d;
		end
	end
	assign flag = flag_q;
	a_set_wins: assert property (@(posedge clk) disable iff (reset) setPulse |=> flag_q)
		else $error("sticky bit lost a set");
endmodule
`default_nettype wire

// ### design/wdog_sync3.sv
// Purpose: Three-stage synchroniser with agreement filter for a pin input
// Assumes: Input is asynchronous to clk
// Notes: Output changes once stages two and three agree
`timescale 1ns/10ps
`default_nettype none
module wdog_sync3 (
	input wire logic clk,
	input wire logic reset,
	input wire logic pinIn,
	output logic level
);
	logic [2:0] stage_q;
	logic [2:0] stage_d;
	logic level_q;
	logic level_d;
	// First stage feeds only the second
	always_comb begin
		stage_d = {stage_q[1:0], pinIn};
		level_d = level_q;
		if (stage_q[1] == stage_q[2]) begin
			level_d = stage_q[2];
		end
	end
	always_ff @(posedge clk) begin
		if (reset) begin
			stage_q <= 3'h0;
			level_q <= 1'b0;
		end else begin
			stage_q <= stage_d;
			level_q <= level_d;
		end
	end
	assign level = level_q;
endmodule
`default_nettype wire

// ### testbench/tb_wdog_irq_status.sv
// Purpose: Self-checking bench for the watchdog interrupt and status block
// Assumes: AXI4-Lite master tasks, 25 MHz clock, synchronous reset
// Notes: Small periods are written in relaxed mode to keep runs short
`timescale 1ns/10ps
`default_nettype none
module tb_wdog_irq_status;
	import wdog_pkg::*;
	logic clk, reset, debuggerPin;
	logic [7:0] awAddr, arAddr;
	logic awValid, wValid, bReady, arValid, rReady;
	logic [31:0] wData;
	logic [3:0] wStrb;
	logic awReady, wReady, bValid, arReady, rValid, hostIrq, hostResetReq, eventIrq;
	logic [1:0] bResp, rResp;
	logic [31:0] rData, rd, c1;
	logic [1:0] rsp;
	int miscompares, n_tests, cycles, pulses;

	wdog_irq_status dut (.clk(clk), .reset(reset), .debuggerPin(debuggerPin),
		.s_axi_awaddr(awAddr), .s_axi_awvalid(awValid), .s_axi_awready(awReady),
		.s_axi_wdata(wData), .s_axi_wstrb(wStrb), .s_axi_wvalid(wValid), .s_axi_wready(wReady),
		.s_axi_bresp(bResp), .s_axi_bvalid(bValid), .s_axi_bready(bReady),
		.s_axi_araddr(arAddr), .s_axi_arvalid(arValid), .s_axi_arready(arReady),
		.s_axi_rdata(rData), .s_axi_rresp(rResp), .s_axi_rvalid(rValid), .s_axi_rready(rReady),
		.hostIrq(hostIrq), .hostResetReq(hostResetReq), .eventIrq(eventIrq));

	// Free-running clock, 40 ns period
	initial begin
		clk = 1'b0;
		forever #20 clk = ~clk;
	end

	////////////////////////////////////////////////////////////////////////
	task automatic print_verdict();
		$display("Comparisons %0d, mismatches %0d", n_tests, miscompares);
		if (miscompares == 0 && n_tests > 0) begin
			$display("Regression OK");
		end else begin
			$display("Regression broken");
		end
		$finish;
	endtask

	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		n_tests++;
		if (seen !== exp) begin
			miscompares++;
			$display("Error at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask

	// Hang guard: whole run needs about three hundred cycles
	always @(posedge clk) begin
		cycles++;
		if (cycles == 1000) begin
			miscompares++;
			print_verdict();
		end
	end

	// Called just after a rising edge; each request is held until its ready is seen at an edge.
	// One spare edge closes every call, so back-to-back calls never drive a signal twice at once.
	task automatic axiWrite(input logic [7:0] a, input logic [31:0] d, output logic [1:0] resp);
		logic b;
		b = 1'b0;
		awAddr <= a;
		wData <= d;
		awValid <= 1'b1;
		wValid <= 1'b1;
		bReady <= 1'b1;
		while (!b) begin
			@(posedge clk);
			if (awValid && awReady === 1'b1) awValid <= 1'b0;
			if (wValid && wReady === 1'b1) wValid <= 1'b0;
			b = (bValid === 1'b1);
			resp = bResp;
		end
		bReady <= 1'b0;
		@(posedge clk);
	endtask

	task automatic axiRead(input logic [7:0] a, output logic [31:0] d, output logic [1:0] resp);
		logic r;
		r = 1'b0;
		arAddr <= a;
		arValid <= 1'b1;
		rReady <= 1'b1;
		while (!r) begin
			@(posedge clk);
			if (arValid && arReady === 1'b1) arValid <= 1'b0;
			r = (rValid === 1'b1);
			d = rData;
			resp = rResp;
		end
		rReady <= 1'b0;
		@(posedge clk);
	endtask

	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		axiWrite(a, d, rsp);
		check({30'h0, rsp}, {30'h0, RESP_OKAY});
	endtask

	task automatic rdChk(input logic [7:0] a, input logic [31:0] exp);
		axiRead(a, rd, rsp);
		check(rd, exp);
	endtask

	function automatic logic [31:0] st(input logic p, input logic r, input logic a, input logic g);
		st = (32'(p) << ST_PEND_BIT) | (32'(r) << ST_RELAXED_BIT) | (32'(a) << ST_ACTIVE_BIT) | (32'(g) << ST_DEBUG_BIT);
	endfunction

	// Stays on rising edges so the next task starts where the bus master must
	task automatic idle(input int n);
		repeat (n) @(posedge clk);
	endtask

	////////////////////////////////////////////////////////////////////////
	initial begin
		reset = 1'b1; debuggerPin = 1'b0; awAddr = 8'h00; arAddr = 8'h00; wData = 32'h0; wStrb = 4'hF;
		awValid = 1'b0; wValid = 1'b0; bReady = 1'b0; arValid = 1'b0; rReady = 1'b0;
		miscompares = 0; n_tests = 0; cycles = 0; pulses = 0;
		repeat (10) @(posedge clk);
		reset <= 1'b0;
		// Reset state
		rdChk(OFF_CTRL, 32'h0);
		rdChk(OFF_STATUS, st(0, 0, 0, 0));
		rdChk(OFF_PERIOD, PERIOD_RESET);
		rdChk(OFF_COUNT, PERIOD_RESET);
		// Safety mode: period and action changes refused, reject event raised
		wr(OFF_PERIOD, 32'h14);
		rdChk(OFF_PERIOD, PERIOD_RESET);
		wr(OFF_CTRL, 32'(ACT_HOST_IRQ));
		rdChk(OFF_CTRL, 32'h0);
		rdChk(OFF_IRQ_STAT, 32'h1 << EV_REJECT_BIT);
		check({31'h0, eventIrq}, 32'h0);
		wr(OFF_IRQ_MASK, 32'h1 << EV_REJECT_BIT);
		idle(2);
		check({31'h0, eventIrq}, 32'h1);
		wr(OFF_IRQ_STAT, 32'h1 << EV_REJECT_BIT);
		idle(2);
		check({31'h0, eventIrq}, 32'h0);
		rdChk(OFF_IRQ_STAT, 32'h0);
		// Relaxed mode accepts settings at runtime
		wr(OFF_CTRL, 32'h1 << CTRL_RELAXED_BIT);
		wr(OFF_CTRL, (32'h1 << CTRL_RELAXED_BIT) | 32'(ACT_HOST_IRQ));
		wr(OFF_PERIOD, 32'h14);
		rdChk(OFF_PERIOD, 32'h14);
		// Partial strobe on a full-word field is ignored but still answered OKAY
		wStrb <= 4'h1;
		wr(OFF_PERIOD, 32'h30);
		wStrb <= 4'hF;
		rdChk(OFF_PERIOD, 32'h14);
		rdChk(OFF_CTRL, (32'h1 << CTRL_RELAXED_BIT) | 32'(ACT_HOST_IRQ));
		rdChk(OFF_STATUS, st(0, 1, 1, 0));
		wr(OFF_CMD, 32'h1 << CMD_RELOAD_BIT);
		axiRead(OFF_COUNT, rd, rsp);
		check({31'h0, rd <= 32'h14 && rd >= 32'h0A}, 32'h1);
		// Expiry while forwarding is off; wait chosen so the later count read avoids zero
		idle(25);
		rdChk(OFF_STATUS, st(1, 1, 1, 0));
		check({31'h0, hostIrq}, 32'h0);
		rdChk(OFF_IRQ_STAT, 32'h1 << EV_EXPIRY_BIT);
		axiRead(OFF_COUNT, rd, rsp);
		check({31'h0, rd <= 32'h14 && rd != 32'h0}, 32'h1);
		// Forwarding on, then off again
		wr(OFF_CMD, 32'h1 << CMD_FWD_EN_BIT);
		idle(3);
		check({31'h0, hostIrq}, 32'h1);
		rdChk(OFF_CTRL, (32'h1 << CTRL_FWD_BIT) | (32'h1 << CTRL_RELAXED_BIT) | 32'(ACT_HOST_IRQ));
		wr(OFF_CMD, 32'h1 << CMD_FWD_DIS_BIT);
		idle(3);
		check({31'h0, hostIrq}, 32'h0);
		rdChk(OFF_STATUS, st(1, 1, 1, 0));
		// Inactive counter holds still, so acknowledge must not move it
		wr(OFF_CTRL, 32'h1 << CTRL_RELAXED_BIT);
		axiRead(OFF_COUNT, c1, rsp);
		wr(OFF_CMD, 32'h1 << CMD_ACK_BIT);
		rdChk(OFF_COUNT, c1);
		idle(30);
		rdChk(OFF_STATUS, st(0, 1, 0, 0));
		// Attached debugger forces the watchdog inactive
		wr(OFF_CTRL, (32'h1 << CTRL_RELAXED_BIT) | 32'(ACT_HOST_IRQ));
		debuggerPin <= 1'b1;
		idle(8);
		axiRead(OFF_STATUS, rd, rsp);
		check(rd & st(0, 1, 1, 1), st(0, 1, 0, 1));
		debuggerPin <= 1'b0;
		idle(8);
		axiRead(OFF_STATUS, rd, rsp);
		check(rd & st(0, 1, 1, 1), st(0, 1, 1, 0));
		// Host reset action: one pulse per expiry; reload precedes acknowledge
		wr(OFF_CTRL, (32'h1 << CTRL_RELAXED_BIT) | 32'(ACT_HOST_RESET));
		wr(OFF_CMD, 32'h1 << CMD_RELOAD_BIT);
		wr(OFF_CMD, 32'h1 << CMD_ACK_BIT);
		repeat (30) begin
			@(posedge clk);
			pulses += int'(hostResetReq === 1'b1);
		end
		check(32'(pulses), 32'h1);
		rdChk(OFF_STATUS, st(0, 1, 1, 0));
		// Unmapped and unaligned places
		axiRead(8'h1C, rd, rsp);
		check({30'h0, rsp}, {30'h0, RESP_SLVERR});
		axiRead(8'h02, rd, rsp);
		check({30'h0, rsp}, {30'h0, RESP_SLVERR});
		axiWrite(8'h20, 32'hFF, rsp);
		check({30'h0, rsp}, {30'h0, RESP_SLVERR});
		print_verdict();
	end
endmodule
`default_nettype wire
